// file: design/codec_serial_pkg.sv
// Shared constants for the companding codec serial side
package codec_serial_pkg;
  // Word layout: sign, chord, step, most significant bit first
  localparam int WORD_BITS = 8;
  localparam int SIGN_POS = 7;
  localparam int CHORD_HI = 6;
  localparam int CHORD_LO = 4;
  localparam int STEP_HI = 3;
  localparam int STEP_LO = 0;
  localparam int SIG_POS = 0;
  localparam int CHORD_BITS = 3;
  localparam int STEP_BITS = 4;
  localparam int CNT_BITS = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_FULL = 4'h8;
  // Master clock rate and offset adjustment time
  localparam int CLK_PERIOD_NS = 25;
  localparam int OFFSET_TIME_NS = 1000;
  localparam int OFFSET_CYCLES = (OFFSET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CODE_RESET = 8'hff;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_OFFSET = 2'b01,
    CONV_RUN = 2'b10
  } conv_state_t;
endpackage

// file: design/level_sync.sv
// Two flip-flop synchroniser for a group of level signals
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        meta_ff[i] <= async_in[i];
        sync_out[i] <= meta_ff[i];
      end
    end
  endgenerate
endmodule

// file: design/codec_serial.sv
// Serial framing, signalling and conversion sequencing of the codec
`timescale 1ns/1ps
// How it works
// RQ1 - Controller returns syncs low between words
// RQ2 - Transmit sync low one master clock first
// RQ3 - Receive sync low seventeen master clocks first
// RQ4 - Signalling bit replaces last transmitted step bit
// RQ5 - Select rising picks A, falling picks B
// RQ6 - Received bit eight routed by select edges
// RQ7 - Selects change only at frames six, twelve
// RQ8 - Offset adjustment precedes every conversion
// RQ9 - Word is sign, three chord, four step
// RQ10 - Chord code inverted: 111 smallest, 000 largest
// RQ11 - Sign one positive, zero negative
// RQ12 - First bit taken with sync and clock high
// RQ13 - Syncs spaced 125 us, eight bits wide
// RQ14 - Bit clocks between 0.064 and 2.1 MHz
// RQ15 - Output driven during sync, shifted on rising edges
// RQ16 - Receive sync drops before ninth edge
// RQ17 - Decoding starts after receive sync falls
// RQ18 - Most significant bit first, sign leads
module codec_serial #(
  parameter int WORD_W = codec_serial_pkg::WORD_BITS,
  parameter int OFFSET_LEN = codec_serial_pkg::OFFSET_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  output logic tx_data_out,
  output logic tx_data_oe,
  input wire logic sig_a_in,
  input wire logic sig_b_in,
  input wire logic tx_signal_select,
  input wire logic sig_insert_en,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic rx_data_in,
  input wire logic rx_signal_select,
  output logic sig_a_out,
  output logic sig_b_out,
  output logic offset_null,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic adc_sign,
  input wire logic [2:0] adc_mag,
  input wire logic [3:0] adc_step,
  output logic dac_load,
  output logic [7:0] dac_code
);
  // Refuse word widths the fixed layout cannot serve, and offset cycles shorter than one clock
  generate
    if (WORD_W != codec_serial_pkg::WORD_BITS) begin : g_bad_width
      $error("codec_serial supports only the eight bit word");
    end
    if (OFFSET_LEN < 1) begin : g_bad_offset
      $error("codec_serial offset cycle must last at least one clock");
    end
  endgenerate

  // Master clock domain
  logic tx_sync_s;
  logic rx_sync_s;
  logic rx_sel_s;
  logic tx_sync_d_ff;
  logic rx_sync_d_ff;
  logic rx_sel_d_ff;
  codec_serial_pkg::conv_state_t state_ff;
  codec_serial_pkg::conv_state_t nxt_state;
  logic [15:0] off_cnt_ff;
  logic [7:0] tx_word_ff;
  logic tx_word_tog_ff;
  logic rx_route_a_ff;
  logic [7:0] rx_shift_ff;

  // Frame syncs and receive select come from other clocks
  level_sync #(.WIDTH(3)) u_clk_sync (
    .clk(clk),
    .async_in({tx_frame_sync, rx_frame_sync, rx_signal_select}),
    .sync_out({tx_sync_s, rx_sync_s, rx_sel_s})
  );

  // Edge history of synchronised pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_sync_d_ff <= 1'b0;
      rx_sync_d_ff <= 1'b0;
      rx_sel_d_ff <= 1'b0;
    end else begin
      tx_sync_d_ff <= tx_sync_s;
      rx_sync_d_ff <= rx_sync_s;
      rx_sel_d_ff <= rx_sel_s;
    end
  end

  // Conversion sequencer, offset cycle never skipped
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      codec_serial_pkg::CONV_IDLE: begin
        if (tx_sync_s && !tx_sync_d_ff) begin
          nxt_state = codec_serial_pkg::CONV_OFFSET; // RQ8
        end
      end
      codec_serial_pkg::CONV_OFFSET: begin
        if (off_cnt_ff == 16'(OFFSET_LEN - 1)) begin
          nxt_state = codec_serial_pkg::CONV_RUN;
        end
      end
      codec_serial_pkg::CONV_RUN: begin
        if (adc_done) begin
          nxt_state = codec_serial_pkg::CONV_IDLE;
        end
      end
      default: nxt_state = codec_serial_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= codec_serial_pkg::CONV_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Offset cycle length counter
  always_ff @(posedge clk) begin
    if (!rstn || state_ff != codec_serial_pkg::CONV_OFFSET) begin
      off_cnt_ff <= 16'h0000;
    end else begin
      off_cnt_ff <= off_cnt_ff + 16'h0001;
    end
  end

  // Converter strobes; start is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (!rstn) begin
      offset_null <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      offset_null <= (nxt_state == codec_serial_pkg::CONV_OFFSET); // RQ8
      adc_start <= (state_ff == codec_serial_pkg::CONV_OFFSET) &&
                   (nxt_state == codec_serial_pkg::CONV_RUN);
    end
  end

  // Format the result; toggle tells the transmit side
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_word_ff <= codec_serial_pkg::CODE_RESET;
      tx_word_tog_ff <= 1'b0;
    end else if (state_ff == codec_serial_pkg::CONV_RUN && adc_done) begin
      tx_word_ff[codec_serial_pkg::SIGN_POS] <= adc_sign; // RQ11
      tx_word_ff[codec_serial_pkg::CHORD_HI:codec_serial_pkg::CHORD_LO] <= ~adc_mag; // RQ10
      tx_word_ff[codec_serial_pkg::STEP_HI:codec_serial_pkg::STEP_LO] <= adc_step; // RQ9
      tx_word_tog_ff <= ~tx_word_tog_ff;
    end
  end

  // Receive word is stable while the sync stays low
  // Limitation: no handshake back to the line side, so the line
  // must keep the sync low a few master clocks before the next word
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dac_load <= 1'b0;
      dac_code <= codec_serial_pkg::CODE_RESET;
    end else begin
      dac_load <= rx_sync_d_ff && !rx_sync_s; // RQ17
      if (rx_sync_d_ff && !rx_sync_s) begin
        dac_code <= rx_shift_ff; // RQ17 RQ3
      end
    end
  end

  // Receive select edges steer bit eight
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_route_a_ff <= 1'b1;
    end else if (rx_sel_s && !rx_sel_d_ff) begin
      rx_route_a_ff <= 1'b1; // RQ6
    end else if (!rx_sel_s && rx_sel_d_ff) begin
      rx_route_a_ff <= 1'b0; // RQ6
    end
  end

  // Signalling outputs hold between frames
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sig_a_out <= 1'b0;
      sig_b_out <= 1'b0;
    end else if (rx_sync_d_ff && !rx_sync_s) begin
      if (rx_route_a_ff) begin
        sig_a_out <= rx_shift_ff[codec_serial_pkg::SIG_POS]; // RQ6
      end else begin
        sig_b_out <= rx_shift_ff[codec_serial_pkg::SIG_POS]; // RQ6
      end
    end
  end

  // Transmit bit clock domain
  logic tx_rstn_s;
  logic tog_s;
  logic sel_s;
  logic sa_s;
  logic sb_s;
  logic ins_s;
  logic sel_d_ff;
  logic sel_a_ff;
  logic tog_seen_ff;
  logic [7:0] tx_hold_ff;
  logic [7:0] tx_sreg_ff;
  logic [3:0] tx_cnt_ff;
  logic [7:0] tx_load;

  // Reset, toggle and signalling pins into the transmit domain
  level_sync #(.WIDTH(6)) u_tx_sync (
    .clk(tx_bit_clock),
    .async_in({rstn, tx_word_tog_ff, tx_signal_select, sig_a_in, sig_b_in, sig_insert_en}),
    .sync_out({tx_rstn_s, tog_s, sel_s, sa_s, sb_s, ins_s})
  );

  // Transmit select edges choose the inserted source
  always_ff @(posedge tx_bit_clock) begin
    if (!tx_rstn_s) begin
      sel_d_ff <= 1'b0;
      sel_a_ff <= 1'b1;
    end else begin
      sel_d_ff <= sel_s;
      if (sel_s && !sel_d_ff) begin
        sel_a_ff <= 1'b1; // RQ5
      end else if (!sel_s && sel_d_ff) begin
        sel_a_ff <= 1'b0; // RQ5
      end
    end
  end

  // Take a new word only between frames, so none tears mid-shift
  always_ff @(posedge tx_bit_clock) begin
    if (!tx_rstn_s) begin
      tog_seen_ff <= 1'b0;
      tx_hold_ff <= codec_serial_pkg::CODE_RESET;
    end else if (!tx_frame_sync && tog_s != tog_seen_ff) begin
      tog_seen_ff <= tog_s;
      tx_hold_ff <= tx_word_ff;
    end
  end

  // Last step bit gives way to the signalling bit
  // Select and signalling levels are taken once, at the load edge
  always_comb begin
    tx_load = tx_hold_ff;
    if (ins_s) begin
      tx_load[codec_serial_pkg::SIG_POS] = sel_a_ff ? sa_s : sb_s; // RQ4
    end
  end

  // Shift out on rising edges while the sync is high
  always_ff @(posedge tx_bit_clock) begin
    if (!tx_rstn_s) begin
      tx_cnt_ff <= codec_serial_pkg::CNT_ZERO;
      tx_sreg_ff <= codec_serial_pkg::CODE_RESET;
      tx_data_out <= 1'b0;
    end else if (!tx_frame_sync) begin
      tx_cnt_ff <= codec_serial_pkg::CNT_ZERO;
    end else if (tx_cnt_ff == codec_serial_pkg::CNT_ZERO) begin
      tx_sreg_ff <= tx_load;
      tx_data_out <= tx_load[codec_serial_pkg::SIGN_POS]; // RQ18
      tx_cnt_ff <= codec_serial_pkg::CNT_ONE;
    end else if (tx_cnt_ff < codec_serial_pkg::CNT_FULL) begin
      tx_sreg_ff <= {tx_sreg_ff[codec_serial_pkg::SIGN_POS-1:0], 1'b0}; // RQ15
      tx_data_out <= tx_sreg_ff[codec_serial_pkg::SIGN_POS-1]; // RQ18
      tx_cnt_ff <= tx_cnt_ff + codec_serial_pkg::CNT_ONE;
    end
  end

  // Pin released as soon as the sync falls
  assign tx_data_oe = tx_frame_sync; // RQ15

  // Receive bit clock domain
  logic rx_rstn_s;
  logic [3:0] rx_cnt_ff;

  level_sync #(.WIDTH(1)) u_rx_sync (
    .clk(rx_bit_clock),
    .async_in(rstn),
    .sync_out(rx_rstn_s)
  );

  // Shift in while sync and clock are high; extra edges ignored
  always_ff @(posedge rx_bit_clock) begin
    if (!rx_rstn_s) begin
      rx_cnt_ff <= codec_serial_pkg::CNT_ZERO;
      rx_shift_ff <= codec_serial_pkg::CODE_RESET;
    end else if (!rx_frame_sync) begin
      rx_cnt_ff <= codec_serial_pkg::CNT_ZERO;
    end else if (rx_cnt_ff < codec_serial_pkg::CNT_FULL) begin
      rx_shift_ff <= {rx_shift_ff[codec_serial_pkg::SIGN_POS-1:0], rx_data_in}; // RQ12 RQ18
      rx_cnt_ff <= rx_cnt_ff + codec_serial_pkg::CNT_ONE; // RQ16
    end
  end
endmodule

// file: sim/codec_serial_asserts.sv
// Port-level assertions for the codec serial block
`timescale 1ns/1ps
module codec_serial_asserts #(
  parameter int OFFSET_LEN = 40
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tx_frame_sync,
  input wire logic tx_data_oe,
  input wire logic rx_frame_sync,
  input wire logic offset_null,
  input wire logic adc_start,
  input wire logic dac_load,
  input wire logic [7:0] dac_code,
  input wire logic sig_a_out,
  input wire logic sig_b_out
);
  logic [7:0] off_cnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Length of the running offset cycle; a stuck null would grow it
  always_ff @(posedge clk) begin
    off_cnt_ff <= (!rstn || !offset_null) ? 8'h00 : off_cnt_ff + 8'h01;
  end
  oe_follow_a: assert property (tx_data_oe == tx_frame_sync)
    else $error("output enable differs from transmit sync");
  offset_trig_a: assert property ($rose(tx_frame_sync) |-> ##[1:6] offset_null)
    else $error("no offset cycle after transmit sync");
  offset_len_a: assert property (off_cnt_ff <= 8'(OFFSET_LEN))
    else $error("offset cycle too long");
  start_after_offset_a: assert property (adc_start |-> $past(offset_null) && !offset_null)
    else $error("conversion start without offset cycle");
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  load_after_fall_a: assert property ($fell(rx_frame_sync) |-> ##[1:6] dac_load)
    else $error("no load after receive sync fell");
  load_sync_low_a: assert property (dac_load |-> !rx_frame_sync)
    else $error("load while receive sync high");
  code_hold_a: assert property ($changed(dac_code) |-> dac_load)
    else $error("received code changed without load");
  sig_hold_a: assert property ($changed({sig_a_out, sig_b_out}) |-> dac_load)
    else $error("signalling outputs changed without load");
endmodule

bind codec_serial codec_serial_asserts #(.OFFSET_LEN(OFFSET_LEN)) i_chk (.clk(clk), .rstn(rstn),
  .tx_frame_sync(tx_frame_sync), .tx_data_oe(tx_data_oe), .rx_frame_sync(rx_frame_sync),
  .offset_null(offset_null), .adc_start(adc_start), .dac_load(dac_load), .dac_code(dac_code),
  .sig_a_out(sig_a_out), .sig_b_out(sig_b_out));

// file: sim/highway_model.sv
// Stand-in for the PCM highway controller: bit clock, syncs, receive data
`timescale 1ns/1ps
module highway_model (
  input wire logic tx_data_out,
  input wire logic tx_data_oe,
  output logic bclk,
  output logic tx_fs,
  output logic rx_fs,
  output logic rx_dat
);
  realtime t_tx = -125000.0;
  realtime t_rx = -125000.0;
  // Free-running line clock, faster than a real line to keep runs short
  initial begin
    {bclk, tx_fs, rx_fs, rx_dat} = 4'h0;
    #7;
    forever #80 bclk = ~bclk;
  end
  // Frame period between sync pulses; also leaves the sync low long enough
  task automatic spacing(inout realtime t_last);
    while ($realtime - t_last < 125000.0) @(negedge bclk);
    @(negedge bclk);
    t_last = $realtime;
  endtask
  // One transmit word, taken after each rise, sync dropped after eight bits
  task automatic tx_frame(output logic [7:0] w, output logic oe_seen);
    spacing(t_tx);
    tx_fs = 1'b1;
    oe_seen = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(negedge bclk);
      w[i] = tx_data_out;
      oe_seen &= tx_data_oe;
    end
    tx_fs = 1'b0;
    #1 oe_seen &= !tx_data_oe;
  endtask
  // One receive word, first bit ready while sync and clock are high
  task automatic rx_frame(input logic [7:0] w);
    spacing(t_rx);
    rx_fs = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      rx_dat = w[i];
      @(negedge bclk);
    end
    rx_fs = 1'b0;
    rx_dat = ~rx_dat; // Released line shows no stale bit
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the codec serial block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bclk, tx_fs, rx_fs, rx_dat, tx_out, tx_oe, off_null, adc_start, load;
  logic sig_a, sig_b, tx_sel, ins_en, rx_sel, sa_out, sb_out, adc_sign;
  logic adc_done = 1'b0;
  logic [2:0] adc_mag;
  logic [3:0] adc_step;
  logic [7:0] code;
  int error_cnt = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  // Converter stand-in answers half a cycle after each start, on the falling clock edge
  always @(negedge clk) adc_done <= adc_start;
  highway_model i_hw (.tx_data_out(tx_out), .tx_data_oe(tx_oe), .bclk(bclk), .tx_fs(tx_fs),
    .rx_fs(rx_fs), .rx_dat(rx_dat));
  codec_serial #(.OFFSET_LEN(2)) i_dut (.clk(clk), .rstn(rstn), .tx_bit_clock(bclk),
    .tx_frame_sync(tx_fs), .tx_data_out(tx_out), .tx_data_oe(tx_oe), .sig_a_in(sig_a),
    .sig_b_in(sig_b), .tx_signal_select(tx_sel), .sig_insert_en(ins_en), .rx_bit_clock(bclk),
    .rx_frame_sync(rx_fs), .rx_data_in(rx_dat), .rx_signal_select(rx_sel), .sig_a_out(sa_out),
    .sig_b_out(sb_out), .offset_null(off_null), .adc_start(adc_start), .adc_done(adc_done),
    .adc_sign(adc_sign), .adc_mag(adc_mag), .adc_step(adc_step), .dac_load(load), .dac_code(code));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Raw converter results {sign, magnitude, step}; word lags one frame
  task automatic t_encode;
    logic [7:0] w;
    logic ok;
    logic [7:0] tbl [3] = '{8'had, 8'h70, 8'h0f};
    for (int i = 0; i <= 3; i++) begin
      @(negedge clk);
      if (i < 3) {adc_sign, adc_mag, adc_step} = tbl[i];
      i_hw.tx_frame(w, ok);
      check("oe", {7'h0, ok}, 8'h01);
      if (i > 0) check("tx word", w, {tbl[i-1][7], ~tbl[i-1][6:4], tbl[i-1][3:0]});
    end
    $display("encode test done");
  endtask
  // Select rise then fall; the second frame after a change carries it
  task automatic t_signal;
    logic [7:0] w;
    logic ok;
    {ins_en, sig_a, sig_b} = 3'b110;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      if (i % 2 == 0) tx_sel = ~tx_sel;
      i_hw.tx_frame(w, ok);
      if (i % 2 == 1) check("sig bit", {7'h0, w[0]}, {7'h0, tx_sel});
    end
    $display("signal insert test done");
  endtask
  // Received words with the select toggled before each
  task automatic t_rx;
    logic [7:0] wd [3] = '{8'h81, 8'h5b, 8'h26};
    logic ea = 1'b0;
    logic eb = 1'b0;
    int k;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      rx_sel = ~rx_sel;
      i_hw.rx_frame(wd[i]);
      k = 0;
      while (load !== 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      check("load", {7'h0, load}, 8'h01);
      check("code", code, wd[i]);
      if (rx_sel) ea = wd[i][0];
      else eb = wd[i][0];
      check("sig out", {6'h0, sa_out, sb_out}, {6'h0, ea, eb});
    end
    $display("receive test done");
  endtask
  initial begin
    {tx_sel, rx_sel, ins_en, sig_a, sig_b} = 5'h00;
    {adc_sign, adc_mag, adc_step} = 8'h00;
    // Long enough for both line domains to see the reset
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (40) @(negedge clk);
    check("reset code", code, 8'hff);
    t_encode();
    t_signal();
    t_rx();
    end_sim();
  end
  // Watchdog: about twice the expected run time
  initial begin
    #2200000;
    error_cnt++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end
endmodule
